// File: tgc_timer_gate.sv
// Timer control block: register slave, pin gating, capture reload and single shot.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Gating enable lets the pin level gate the wide timer or upper byte timer.
// - The low byte timer in dual mode is never gated by the pin.
// - Both-edge capture reload with gating skips the reload on one pin edge.
// - Single shot overrides or delays the run enable, running one cycle anyway.
// - Single shot in compare mode outputs exactly one reload-to-overflow waveform.
// - With gating defined, the single shot waits until the gate releases.
// - If the pin already shows the pass level, the single shot starts at once.
// - A gated single shot is not supported in dual byte mode.
// - The control register is always readable and writable.
// - Run enable starts and stops the timer; stopped counts hold their value unless a capture reload or a single shot start loads them.
// - Low timer run bit acts only in dual byte mode.
// - Polarity sets output start level, or the pass level of the gate input.
module tgc_timer_gate #(
   parameter int CNT_W = 16
) (
   input wire logic CLK, // system clock, 20 MHz
   input wire logic RESET_N, // asynchronous reset, active low
   input wire logic WB_CYC_I, // bus cycle
   input wire logic WB_STB_I, // bus strobe
   input wire logic WB_WE_I, // write enable
   input wire logic [tgc_pkg::ADR_W-1:0] WB_ADR_I, // byte address
   input wire logic [3:0] WB_SEL_I, // byte enables
   input wire logic [31:0] WB_DAT_I, // write data
   output logic [31:0] WB_DAT_O, // read data
   output logic WB_ACK_O, // acknowledge
   input wire logic TIMER_PRIMARY_PIN_I, // primary pin level
   output logic TIMER_PRIMARY_PIN_O, // primary pin drive level
   output logic TIMER_PRIMARY_PIN_OE, // primary pin output enable
   output logic TIMER_COMPLEMENT_PIN_O, // complement pin drive level
   output logic TIMER_COMPLEMENT_PIN_OE // complement pin output enable
);
   if (CNT_W < 4 || CNT_W > 32 || (CNT_W % 2) != 0) begin : g_chk
      $error("CNT_W must be even and between 4 and 32");
   end
   localparam int HW = CNT_W / 2;

   // ---------------------------------------------------------------
   // Bus slave.
   // ---------------------------------------------------------------
   logic ack_q;
   logic [31:0] dat_q;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] mode_q;
   logic [CNT_W-1:0] reload_q, cmp_q, cap_q;
   tgc_core_if #(.CNT_W(CNT_W)) cif ();

   wire bus_req = WB_CYC_I & WB_STB_I & ~ack_q;
   wire bus_wr = bus_req & WB_WE_I;
   wire hit_ctrl = WB_ADR_I == tgc_pkg::OFS_CTRL_A;
   wire hit_mode = WB_ADR_I == tgc_pkg::OFS_MODE;
   wire hit_rel = WB_ADR_I == tgc_pkg::OFS_RELOAD;
   wire hit_cmp = WB_ADR_I == tgc_pkg::OFS_COMPARE;
   wire hit_cnt = WB_ADR_I == tgc_pkg::OFS_COUNT;
   wire hit_cap = WB_ADR_I == tgc_pkg::OFS_CAPTURE;
   wire wr_ctrl = bus_wr & hit_ctrl & WB_SEL_I[0];
   wire wr_mode = bus_wr & hit_mode;
   wire wr_rel = bus_wr & hit_rel;
   wire wr_cmp = bus_wr & hit_cmp;
   wire [31:0] rd_val = hit_ctrl ? 32'(ctrl_q) :
                        hit_mode ? 32'(mode_q) :
                        hit_rel ? 32'(reload_q) :
                        hit_cmp ? 32'(cmp_q) :
                        hit_cnt ? 32'(cif.count) :
                        hit_cap ? 32'(cap_q) : 32'h0000_0000;

   // Ack answers one cycle after a request is taken and drops in the cycle after that.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         if (bus_req && !WB_WE_I) begin
            dat_q <= rd_val;
         end
      end
   end
   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;

   // ---------------------------------------------------------------
   // Control fields.
   // ---------------------------------------------------------------
   wire gate_en = ctrl_q[tgc_pkg::CA_GATE];
   wire one_shot_trigger = ctrl_q[tgc_pkg::CA_ONESHOT];
   wire cprl = ctrl_q[tgc_pkg::CA_CPRL];
   wire run_en = ctrl_q[tgc_pkg::CA_RUN];
   wire run_lo_en = ctrl_q[tgc_pkg::CA_RUNLO];
   wire pol0 = ctrl_q[tgc_pkg::CA_POL0];
   wire oe0 = ctrl_q[tgc_pkg::CA_OE0];
   wire dual = mode_q[tgc_pkg::MD_DUAL];
   wire cnt_mode = mode_q[tgc_pkg::MD_COUNTER];
   wire [1:0] edge_sel = mode_q[tgc_pkg::MD_EDGE +: 2];
   wire cmp_mode = mode_q[tgc_pkg::MD_COMPARE];
   wire pol1 = mode_q[tgc_pkg::MD_POL1];
   wire oe1 = mode_q[tgc_pkg::MD_OE1];

   // ---------------------------------------------------------------
   // Pin synchroniser and edges.
   // ---------------------------------------------------------------
   logic pin_s1_q, pin_s2_q, pin_s3_q;
   // The third flop only serves edge detection; all other logic reads the second.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= TIMER_PRIMARY_PIN_I;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end
   wire pin_rise = pin_s2_q & ~pin_s3_q;
   wire pin_fall = ~pin_s2_q & pin_s3_q;

   // ---------------------------------------------------------------
   // Gating, capture and reload.
   // ---------------------------------------------------------------
   wire capture_mode = ~cmp_mode & ~cnt_mode;
   wire both_reload = capture_mode & (edge_sel == tgc_pkg::EDGE_BOTH) & cprl;
   wire skip_cfg = both_reload & gate_en;
   // The gating bit is repurposed for reload skipping in the both-edge case.
   wire gating_on = gate_en & ~both_reload;
   wire gate_ok = ~gating_on | (pin_s2_q == pol0);
   wire cap_evt = capture_mode & ((edge_sel[0] & pin_rise) | (edge_sel[1] & pin_fall));
   wire skip_now = skip_cfg & (pol0 ? pin_rise : pin_fall);
   // A gated single shot is refused in dual mode, and the write then leaves the bit clear.
   wire os_start = wr_ctrl & WB_DAT_I[tgc_pkg::CA_ONESHOT] &
                   ~(mode_q[tgc_pkg::MD_DUAL] & WB_DAT_I[tgc_pkg::CA_GATE]);
   // A skipped edge still captures; only its reload is held back.
   // A single shot reloads at once so that its period starts from the reload value.
   wire load = os_start | (cap_evt & cprl & ~skip_now);

   // ---------------------------------------------------------------
   // Register update; the one-shot set wins over its own completion.
   // ---------------------------------------------------------------
   // Bit 7 reads 0; the mask keeps it clear on every write.
   wire [7:0] ctrl_base = wr_ctrl ?
        8'(tgc_pkg::wmerge(32'(ctrl_q), WB_DAT_I, WB_SEL_I)) & tgc_pkg::REG8_MASK : ctrl_q;
   wire os_done = one_shot_trigger & cif.ovf_hi;
   wire os_next = os_start | (one_shot_trigger & ~os_done & ~wr_ctrl);
   wire [7:0] os_bit = 8'(1) << tgc_pkg::CA_ONESHOT;
   assign ctrl_d = (ctrl_base & ~os_bit) | (os_next ? os_bit : 8'h00);

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_q <= tgc_pkg::CTRL_A_RST;
         mode_q <= tgc_pkg::MODE_RST;
         reload_q <= CNT_W'(tgc_pkg::VALUE_RST);
         cmp_q <= CNT_W'(tgc_pkg::VALUE_RST);
         cap_q <= CNT_W'(tgc_pkg::VALUE_RST);
      end else begin
         ctrl_q <= ctrl_d;
         if (wr_mode) begin
            mode_q <= 8'(tgc_pkg::wmerge(32'(mode_q), WB_DAT_I, WB_SEL_I)) & tgc_pkg::REG8_MASK;
         end
         if (wr_rel) begin
            reload_q <= CNT_W'(tgc_pkg::wmerge(32'(reload_q), WB_DAT_I, WB_SEL_I));
         end
         if (wr_cmp) begin
            cmp_q <= CNT_W'(tgc_pkg::wmerge(32'(cmp_q), WB_DAT_I, WB_SEL_I));
         end
         if (cap_evt) begin
            cap_q <= cif.count;
         end
      end
   end

   // ---------------------------------------------------------------
   // Count core.
   // ---------------------------------------------------------------
   // The core steps every clock in timer mode, or once per synced pin rise in counter mode.
   assign cif.dual = dual;
   assign cif.run_hi = run_en | one_shot_trigger;
   assign cif.run_lo = run_lo_en;
   assign cif.gate_ok = gate_ok;
   assign cif.step = cnt_mode ? pin_rise : 1'b1;
   assign cif.load = load;
   assign cif.reload_val = reload_q;
   assign cif.cmp_val = cmp_q;

   tgc_count_core #(.CNT_W(CNT_W)) u_core (
      .clk(CLK),
      .rst_n(RESET_N),
      .cif(cif)
   );

   // ---------------------------------------------------------------
   // Compare waveform outputs.
   // ---------------------------------------------------------------
   logic phase_q, oe0_q, oe1_q, lvl0_q, lvl1_q, pri_q, cpl_q;
   wire oe0_rise = oe0 & ~oe0_q;
   wire oe1_rise = oe1 & ~oe1_q;
   // Phase is 0 from reload until compare, and 1 from compare until overflow.
   wire phase_d = (load | cif.ovf_hi | oe0_rise) ? 1'b0 :
                  (cmp_mode & cif.cmp_evt) ? 1'b1 : phase_q;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         phase_q <= 1'b0;
         oe0_q <= 1'b0;
         oe1_q <= 1'b0;
         lvl0_q <= 1'b0;
         lvl1_q <= 1'b0;
         pri_q <= 1'b0;
         cpl_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         oe0_q <= oe0;
         oe1_q <= oe1;
         if (oe0_rise) begin
            lvl0_q <= pol0;
         end
         if (oe1_rise) begin
            lvl1_q <= pol1;
         end
         pri_q <= (oe0_rise ? pol0 : lvl0_q) ^ phase_d;
         cpl_q <= (oe1_rise ? pol1 : lvl1_q) ^ phase_d;
      end
   end
   assign TIMER_PRIMARY_PIN_O = pri_q;
   assign TIMER_PRIMARY_PIN_OE = oe0_q;
   assign TIMER_COMPLEMENT_PIN_O = cpl_q;
   assign TIMER_COMPLEMENT_PIN_OE = oe1_q;

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_os_open;
      os_start && !cnt_mode && !dual ##1 (gate_ok && !load);
   endsequence
   sequence s_os_gated;
      os_start && cmp_mode && !dual ##1 (!gate_ok && !load) [*2];
   endsequence

   property p_gate_hold;
      (!dual && gating_on && pin_s2_q != pol0 && !load) |=> $stable(cif.count);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("gated timer advanced");
   property p_low_free;
      (dual && run_lo_en && !load && !cnt_mode && gating_on && !gate_ok)
         |=> cif.count[HW-1:0] != $past(cif.count[HW-1:0]);
   endproperty
   a_low_free: assert property (p_low_free) else $error("low timer was gated");
   property p_skip;
      (skip_cfg && cap_evt && !os_start && (pol0 ? pin_rise : pin_fall)) |-> !load;
   endproperty
   a_skip: assert property (p_skip) else $error("suppressed reload happened");
   property p_os_now;
      s_os_open |=> cif.count != $past(cif.count);
   endproperty
   a_os_now: assert property (p_os_now) else $error("ungated single shot did not run");
   property p_os_end;
      (one_shot_trigger && cif.ovf_hi && !run_en && !wr_ctrl) |=> !cif.run_hi;
   endproperty
   a_os_end: assert property (p_os_end) else $error("single shot ran past overflow");
   property p_os_wait;
      s_os_gated |-> $stable(cif.count) && !phase_q;
   endproperty
   a_os_wait: assert property (p_os_wait) else $error("gated single shot started");
   property p_os_clear;
      (os_done && !wr_ctrl) |=> !one_shot_trigger;
   endproperty
   a_os_clear: assert property (p_os_clear) else $error("single shot not cleared");
   property p_dual_refuse;
      (wr_ctrl && dual && WB_DAT_I[tgc_pkg::CA_GATE]) |=> !one_shot_trigger;
   endproperty
   a_dual_refuse: assert property (p_dual_refuse) else $error("dual gated shot taken");
   property p_ack;
      bus_req |=> WB_ACK_O ##1 !WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer timing wrong");
   property p_pol_start;
      $rose(oe0) |=> lvl0_q == $past(pol0) && TIMER_PRIMARY_PIN_OE;
   endproperty
   a_pol_start: assert property (p_pol_start) else $error("start level not taken");
   sequence s_os_pass;
      os_start && cmp_mode && !dual && gating_on ##1 (gate_ok && !load);
   endsequence
   property p_os_pass;
      s_os_pass |=> cif.count != $past(cif.count);
   endproperty
   a_os_pass: assert property (p_os_pass) else $error("gated single shot did not start");
   property p_reload;
      (skip_cfg && cap_evt && !os_start && !(pol0 ? pin_rise : pin_fall))
         |=> cif.count == $past(reload_q);
   endproperty
   a_reload: assert property (p_reload) else $error("kept reload did not happen");
   property p_low_single;
      (!dual && run_lo_en && !cif.run_hi && !load) |=> $stable(cif.count);
   endproperty
   a_low_single: assert property (p_low_single) else $error("low run bit moved timer");
endmodule
`default_nettype wire

// File: tgc_pkg.sv
// Package of register map, field positions and reset values for the timer gating control.
package tgc_pkg;
   // ---------------------------------------------------------------
   // Register offsets (byte addresses).
   // ---------------------------------------------------------------
   localparam int ADR_W = 8;
   localparam logic [7:0] OFS_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_RELOAD = 8'h08;
   localparam logic [7:0] OFS_COMPARE = 8'h0c;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_CAPTURE = 8'h14;
   // ---------------------------------------------------------------
   // Field positions of timer_two_control_a.
   // ---------------------------------------------------------------
   localparam int CA_GATE = 0;
   localparam int CA_ONESHOT = 1;
   localparam int CA_CPRL = 2;
   localparam int CA_RUN = 3;
   localparam int CA_RUNLO = 4;
   localparam int CA_POL0 = 5;
   localparam int CA_OE0 = 6;
   // ---------------------------------------------------------------
   // Field positions of the mode register.
   // ---------------------------------------------------------------
   localparam int MD_DUAL = 0;
   localparam int MD_COUNTER = 1;
   localparam int MD_EDGE = 2;
   localparam int MD_COMPARE = 4;
   localparam int MD_POL1 = 5;
   localparam int MD_OE1 = 6;
   // ---------------------------------------------------------------
   // Reset values, masks and encodings.
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] REG8_MASK = 8'h7f;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [31:0] VALUE_RST = 32'h0000_0000;

   // Merges write data into an old word under the byte enables.
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = din[8*i +: 8];
         end
      end
      return r;
   endfunction
endpackage

// File: tgc_core_if.sv
// Interface between the control logic and the count core.
`timescale 1ns/1ps
`default_nettype none
interface tgc_core_if #(
   parameter int CNT_W = 16
);
   logic dual;
   logic run_hi;
   logic run_lo;
   logic gate_ok;
   logic step;
   logic load;
   logic [CNT_W-1:0] reload_val;
   logic [CNT_W-1:0] cmp_val;
   logic [CNT_W-1:0] count;
   logic ovf_hi;
   logic ovf_lo;
   logic cmp_evt;
   modport ctl (output dual, run_hi, run_lo, gate_ok, step, load, reload_val, cmp_val,
                input count, ovf_hi, ovf_lo, cmp_evt);
   modport core (input dual, run_hi, run_lo, gate_ok, step, load, reload_val, cmp_val,
                 output count, ovf_hi, ovf_lo, cmp_evt);
endinterface
`default_nettype wire

// File: tgc_count_core.sv
// Count core: one wide counter or two half-width counters with reload.
`timescale 1ns/1ps
`default_nettype none
module tgc_count_core #(
   parameter int CNT_W = 16
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // asynchronous reset, active low
   tgc_core_if.core cif // control side
);
   localparam int HW = CNT_W / 2;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   wire tick_hi = cif.run_hi & cif.gate_ok & cif.step;
   wire tick_lo = cif.dual & cif.run_lo & cif.step;
   wire full_w = &cnt_q;
   wire full_hi = &cnt_q[CNT_W-1:HW];
   wire full_lo = &cnt_q[HW-1:0];
   wire wrap_hi = tick_hi & (cif.dual ? full_hi : full_w);
   wire wrap_lo = tick_lo & full_lo;

   always_comb begin
      cnt_d = cnt_q;
      if (cif.load) begin
         cnt_d = cif.reload_val;
      end else if (!cif.dual) begin
         if (tick_hi) begin
            cnt_d = wrap_hi ? cif.reload_val : cnt_q + 1'b1;
         end
      end else begin
         if (tick_hi) begin
            cnt_d[CNT_W-1:HW] = wrap_hi ? cif.reload_val[CNT_W-1:HW] : cnt_q[CNT_W-1:HW] + 1'b1;
         end
         if (tick_lo) begin
            cnt_d[HW-1:0] = wrap_lo ? cif.reload_val[HW-1:0] : cnt_q[HW-1:0] + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign cif.count = cnt_q;
   assign cif.ovf_hi = wrap_hi & ~cif.load;
   assign cif.ovf_lo = wrap_lo & ~cif.load;
   assign cif.cmp_evt = tick_hi & ~cif.load & ~wrap_hi &
                        (cif.dual ? cnt_d[CNT_W-1:HW] == cif.cmp_val[CNT_W-1:HW]
                                  : cnt_d == cif.cmp_val);

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   property p_stop_holds;
      @(posedge clk) disable iff (!rst_n)
      (!cif.dual && !cif.run_hi && !cif.load) |=> $stable(cnt_q);
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("stopped timer changed count");
   property p_low_run;
      @(posedge clk) disable iff (!rst_n)
      (cif.dual && !cif.run_lo && !cif.load) |=> $stable(cnt_q[HW-1:0]);
   endproperty
   a_low_run: assert property (p_low_run) else $error("stopped low timer changed");
endmodule
`default_nettype wire

// File: tgc_pin_model.sv
// External party at the timer pins: drives the gate level while the pin is an input.
`timescale 1ns/1ps
`default_nettype none
module tgc_pin_model (
   input wire logic drv_o, // level driven by the block
   input wire logic drv_oe, // block output enable
   input wire logic ext_lvl, // level this party puts on the pin
   output logic pin // resolved pin level
);
   // The outside party only drives while the block has the pin as an input.
   assign pin = drv_oe ? drv_o : ext_lvl;
endmodule
`default_nettype wire

// File: tb_timer_gating_single_shot_ctrl.sv
// Self-checking bench of the timer gating and single shot control.
`timescale 1ns/1ps
`default_nettype none
module tb_timer_gating_single_shot_ctrl;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ext_lvl = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, rdat, d1, d2;
   wire logic [31:0] dat_o;
   wire logic ack, p_o, p_oe, c_o, c_oe, pin;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   int miscompares = 0, tests_run = 0, cyc_cnt = 0, rise_p = 0, rise_c = 0, hi_p = 0;
   logic p_prev = 1'b0, c_prev = 1'b0;
   always #25 clk = ~clk;
   tgc_timer_gate #(.CNT_W(16)) dut (.CLK(clk), .RESET_N(reset_n), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack), .TIMER_PRIMARY_PIN_I(pin), .TIMER_PRIMARY_PIN_O(p_o),
      .TIMER_PRIMARY_PIN_OE(p_oe), .TIMER_COMPLEMENT_PIN_O(c_o), .TIMER_COMPLEMENT_PIN_OE(c_oe));
   tgc_pin_model pm (.drv_o(p_o), .drv_oe(p_oe), .ext_lvl(ext_lvl), .pin(pin));
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      tests_run++;
      if (seen !== expv) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One classic Wishbone cycle; a checked read leaves its expectation in the queue.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic chk, input logic [31:0] expv);
      if (!w) begin
         exp_q.push_back({chk, expv});
      end
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 1'b0, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] expv);
      xfer(1'b0, a, 32'h0, 1'b1, expv);
   endtask
   task automatic peek(input logic [7:0] a);
      xfer(1'b0, a, 32'h0, 1'b0, 32'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic clr_pins();
      @(negedge clk);
      rise_p = 0;
      rise_c = 0;
      hi_p = 0;
      @(posedge clk);
   endtask
   // --------------------------------------------------------------
   // Watchers of the read data and of the output pins.
   // --------------------------------------------------------------
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[32]) begin
            check(dat_o, e[31:0]);
         end
      end
      if (p_o === 1'b1 && p_prev === 1'b0) rise_p++;
      if (c_o === 1'b1 && c_prev === 1'b0) rise_c++;
      if (p_o === 1'b1) hi_p++;
      p_prev = p_o;
      c_prev = c_o;
      cyc_cnt++;
      if (cyc_cnt == 6000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      void'($urandom(88757));
      idle(2);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h10, 32'h0);
      rd(8'h1c, 32'h0);
      $display("test reset done");
      // Gate passes only at the polarity level; pin held low.
      wr(8'h00, 32'h29);
      idle(10);
      rd(8'h10, 32'h0);
      wr(8'h00, 32'h09);
      idle(10);
      peek(8'h10);
      check({31'h0, rdat != 32'h0}, 32'h1);
      wr(8'h00, 32'h00);
      peek(8'h10);
      d1 = rdat;
      idle(10);
      rd(8'h10, d1);
      wr(8'h00, 32'h10);
      idle(10);
      rd(8'h10, d1);
      wr(8'h04, 32'h01);
      wr(8'h00, 32'h39);
      idle(20);
      peek(8'h10);
      check({24'h0, rdat[15:8]}, {24'h0, d1[15:8]});
      check({31'h0, rdat[7:0] != d1[7:0]}, 32'h1);
      $display("test gating done");
      wr(8'h08, 32'h8000);
      wr(8'h04, 32'h0c);
      wr(8'h00, 32'h2d);
      peek(8'h10);
      d2 = rdat;
      idle(10);
      peek(8'h10);
      check({31'h0, rdat != d2}, 32'h1);
      ext_lvl <= 1'b1;
      idle(6);
      peek(8'h10);
      check({31'h0, rdat[15]}, 32'h0);
      ext_lvl <= 1'b0;
      idle(6);
      peek(8'h10);
      check({31'h0, rdat[15]}, 32'h1);
      wr(8'h00, 32'h00);
      $display("test both edge reload done");
      wr(8'h00, 32'h60);
      idle(5);
      check({31'h0, p_o}, 32'h1);
      wr(8'h00, 32'h00);
      wr(8'h08, 32'hffe0);
      wr(8'h0c, 32'hfff0);
      wr(8'h04, 32'h50);
      wr(8'h00, 32'h40);
      clr_pins();
      wr(8'h00, 32'h42);
      idle(100);
      check(rise_p, 32'h1);
      check(rise_c, 32'h1);
      check(hi_p, 32'd16);
      check({30'h0, p_oe, c_oe}, 32'h3);
      rd(8'h00, 32'h40);
      $display("test single shot done");
      wr(8'h00, 32'h00);
      clr_pins();
      wr(8'h00, 32'h23);
      idle(60);
      check(rise_c, 32'h0);
      ext_lvl <= 1'b1;
      idle(80);
      check(rise_c, 32'h1);
      rd(8'h00, 32'h21);
      clr_pins();
      wr(8'h00, 32'h23);
      idle(80);
      check(rise_c, 32'h1);
      wr(8'h04, 32'h51);
      wr(8'h00, 32'h23);
      rd(8'h00, 32'h21);
      $display("test gated single shot done");
      for (int i = 0; i < 4; i++) begin
         d1 = $urandom();
         wr(8'h00, d1 & 32'h7d);
         rd(8'h00, {24'h0, d1[7:0] & 8'h7d});
         wr(8'h04, d1 >> 8);
         rd(8'h04, {24'h0, d1[15:8] & 8'h7f});
         wr(8'h20, d1);
         rd(8'h20, 32'h0);
      end
      $display("test register access done");
      results();
   end
endmodule
`default_nettype wire
